// ### core/mwa_pkg.sv
`default_nettype none

package mwa_pkg;

  // ---------------------------------------------------------------------------
  // Register map, word index within a compute block window
  // ---------------------------------------------------------------------------
  localparam logic [2:0] MWA_IDX_LOW_L = 3'h0;
  localparam logic [2:0] MWA_IDX_LOW_H = 3'h1;
  localparam logic [2:0] MWA_IDX_HIGH_L = 3'h2;
  localparam logic [2:0] MWA_IDX_HIGH_H = 3'h3;
  localparam logic [2:0] MWA_IDX_EXT = 3'h4;
  localparam logic [2:0] MWA_IDX_STATUS = 3'h5;
  localparam logic [2:0] MWA_IDX_MASK = 3'h6;
  localparam logic [7:0] MWA_BLK_STRIDE = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int MWA_ST_STICKY = 0;
  localparam int MWA_ST_FLAG_LSB = 1;
  localparam logic [63:0] MWA_ACC_RST = 64'h0;
  localparam logic [31:0] MWA_EXT_RST = 32'h0;
  localparam logic [3:0] MWA_FLAGS_RST = 4'h0;
  localparam logic MWA_MASK_RST = 1'b0;
  localparam logic [81:0] MWA_ROUND = 82'h80000000;
  localparam logic [63:0] MWA_SAT_POS = 64'h7FFFFFFFFFFFFFFF;
  localparam logic [63:0] MWA_SAT_NEG = 64'h8000000000000000;
  localparam logic [63:0] MWA_SAT_UNS = 64'hFFFFFFFFFFFFFFFF;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] blockSel;
    logic accHigh;
    logic subtract;
    logic unsignedOp;
    logic integerOp;
    logic clear;
    logic clearRound;
    logic noFlag;
    logic dual;
    logic pairDest;
    logic [31:0] opA;
    logic [31:0] opB;
  } mwa_op_t;

  typedef struct packed {
    logic valid;
    logic pairDest;
    logic [63:0] data;
  } mwa_copy_t;

  typedef struct packed {
    logic hit;
    logic blk;
    logic [2:0] idx;
  } mwa_dec_t;

endpackage

`default_nettype wire

// ### core/mwa_mac.sv
`default_nettype none

// Operation
// (RULE_01) Multiply operands, add or subtract into accumulator.
// (RULE_02) Target is low pair or high pair.
// (RULE_03) Accumulate 80 bits: pair plus extension.
// (RULE_04) Low pair uses ext 15:0, high 31:16.
// (RULE_05) Zero, negative, overflow, underflow flags untouched.
// (RULE_06) Signed overflow beyond 80-bit signed range sets sticky.
// (RULE_07) Unsigned overflow at 2^80 sets sticky.
// (RULE_08) Unsigned option only for add form.
// (RULE_09) Clear zeroes; clear-and-round zeroes then rounds.
// (RULE_10) No-flag option suppresses all flag updates.
// (RULE_11) Dual form copies old accumulator out.
// (RULE_12) Clear happens after copy, before adding.
// (RULE_13) Extension bits never reach the copy-out.
// (RULE_14) Pair gets 64 bits; single gets low/high half.
// (RULE_15) Single signed integer copy outside 32 bits sets sticky.
// (RULE_16) Signed copy beyond 64 bits saturates, sets sticky.
// (RULE_17) Sticky overflow stays set until software clears.
// (RULE_18) Compute-block selector picks first, second or both.
module mwa_mac
  import mwa_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic opValid,
  input wire mwa_op_t op,
  output mwa_copy_t [1:0] copyOut,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic mwa_dec_t mwa_decode(input logic [7:0] adr);
    mwa_dec_t r;
    r.blk = adr[5];
    r.idx = adr[4:2];
    r.hit = (adr[7:6] == 2'b00) && (adr[1:0] == 2'b00) && (adr[4:2] <= MWA_IDX_MASK);
    return r;
  endfunction

  function automatic logic [31:0] mwa_lanes(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  // Ack follows one cycle after the request; writes land on the ack edge, so
  // a write is seen by the datapath exactly once per bus cycle.
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic busReq, busWr;
  mwa_dec_t rdDec, wrDec;
  logic [1:0][31:0] blkRd;
  logic [1:0] blkIrq;

  assign busReq = wb_cyc_i && wb_stb_i;
  assign busWr = busReq && wb_we_i && ack_q;
  assign rdDec = mwa_decode(wb_adr_i);
  assign wrDec = mwa_decode(wb_adr_i);

  always_comb begin
    ack_d = busReq && !ack_q;
    rdat_d = rdat_q;
    if (busReq && !ack_q) begin
      rdat_d = rdDec.hit ? blkRd[rdDec.blk] : 32'h0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq = |blkIrq;

  // ---------------------------------------------------------------------------
  // Compute blocks
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_blk
    logic [63:0] accLo_q, accLo_d, accHi_q, accHi_d;
    logic [31:0] ext_q, ext_d;
    logic sticky_q, sticky_d, mask_q, mask_d;
    logic [3:0] flags_q, flags_d;
    mwa_copy_t copy_q, copy_d;
    logic issue, isSigned, ovf, copyOvf, wrHere, stickyClr;
    logic [79:0] old80;
    logic [81:0] prod82, base82, sum82;
    logic [63:0] prodU, sat64;
    logic signed [63:0] prodS;
    logic [15:0] oldExt;

    assign issue = opValid && op.blockSel[g]; // RULE_18
    assign wrHere = busWr && wrDec.hit && (wrDec.blk == g[0]);
    assign stickyClr = wrHere && (wrDec.idx == MWA_IDX_STATUS) && wb_sel_i[0]
                       && wb_dat_i[MWA_ST_STICKY];

    always_comb begin
      accLo_d = accLo_q;
      accHi_d = accHi_q;
      ext_d = ext_q;
      mask_d = mask_q;
      flags_d = flags_q;
      copy_d = copy_q;
      copy_d.valid = 1'b0;
      isSigned = op.subtract || !op.unsignedOp; // RULE_08
      prodS = $signed(op.opA) * $signed(op.opB);
      prodU = {32'h0, op.opA} * {32'h0, op.opB}; // RULE_01
      oldExt = op.accHigh ? ext_q[31:16] : ext_q[15:0];
      old80 = op.accHigh ? {oldExt, accHi_q} : {oldExt, accLo_q}; // RULE_02 RULE_03
      prod82 = isSigned ? {{18{prodS[63]}}, prodS} : {18'h0, prodU};
      if (!op.integerOp) begin
        // Fractional 1.31 operands give a 2.62 product; align it to 1.63.
        prod82 = {prod82[80:0], 1'b0};
      end
      // Clearing uses a zero base, or MWA_ROUND for fractional clear-and-round, while the copy below still reads old80.
      if (op.clear || op.clearRound) begin // RULE_09 RULE_12
        base82 = (op.clearRound && !op.integerOp) ? MWA_ROUND : 82'h0;
      end else begin
        base82 = isSigned ? {{2{old80[79]}}, old80} : {2'b00, old80};
      end
      sum82 = op.subtract ? base82 - prod82 : base82 + prod82; // RULE_01
      // The fractional bounds 2^16 and 2^17 are the same 80-bit limits in 17.63.
      if (isSigned) begin
        ovf = (sum82[81:79] != 3'b000) && (sum82[81:79] != 3'b111); // RULE_06
      end else begin
        ovf = sum82[81:80] != 2'b00; // RULE_07
      end
      // Copy-out uses only the 64-bit pair; extension bits steer saturation.
      sat64 = old80[63:0]; // RULE_13
      copyOvf = 1'b0;
      if (isSigned && (oldExt != {16{old80[63]}})) begin // RULE_16
        sat64 = old80[79] ? MWA_SAT_NEG : MWA_SAT_POS;
        copyOvf = 1'b1;
      end else if (!isSigned && (oldExt != 16'h0)) begin
        sat64 = MWA_SAT_UNS;
      end
      if (!op.pairDest && isSigned && op.integerOp
          && (old80[79:31] != {49{old80[79]}})) begin // RULE_15
        copyOvf = 1'b1;
      end
      if (issue) begin
        if (op.accHigh) begin
          accHi_d = sum82[63:0];
          ext_d[31:16] = sum82[79:64]; // RULE_04
        end else begin
          accLo_d = sum82[63:0];
          ext_d[15:0] = sum82[79:64]; // RULE_04
        end
        if (op.dual) begin // RULE_11
          copy_d.valid = 1'b1;
          copy_d.pairDest = op.pairDest;
          if (op.pairDest) begin // RULE_14
            copy_d.data = sat64;
          end else if (op.integerOp) begin
            copy_d.data = {32'h0, sat64[31:0]};
          end else begin
            copy_d.data = {32'h0, sat64[63:32]};
          end
        end
      end else if (wrHere) begin
        // An instruction owns the block in its cycle; a colliding write is lost, except a write-one sticky clear.
        case (wrDec.idx)
          MWA_IDX_LOW_L: accLo_d[31:0] = mwa_lanes(accLo_q[31:0], wb_dat_i, wb_sel_i);
          MWA_IDX_LOW_H: accLo_d[63:32] = mwa_lanes(accLo_q[63:32], wb_dat_i, wb_sel_i);
          MWA_IDX_HIGH_L: accHi_d[31:0] = mwa_lanes(accHi_q[31:0], wb_dat_i, wb_sel_i);
          MWA_IDX_HIGH_H: accHi_d[63:32] = mwa_lanes(accHi_q[63:32], wb_dat_i, wb_sel_i);
          MWA_IDX_EXT: ext_d = mwa_lanes(ext_q, wb_dat_i, wb_sel_i);
          MWA_IDX_STATUS: begin
            if (wb_sel_i[0]) begin
              flags_d = wb_dat_i[MWA_ST_FLAG_LSB +: 4];
            end
          end
          MWA_IDX_MASK: begin
            if (wb_sel_i[0]) begin
              mask_d = wb_dat_i[0];
            end
          end
          default: begin
          end
        endcase
      end
      // Setting wins over a write-one clear in the same cycle.
      sticky_d = (sticky_q && !stickyClr)
                 || (issue && !op.noFlag && (ovf || copyOvf)); // RULE_10 RULE_17
    end

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        accLo_q <= MWA_ACC_RST;
        accHi_q <= MWA_ACC_RST;
        ext_q <= MWA_EXT_RST;
        sticky_q <= 1'b0;
        mask_q <= MWA_MASK_RST;
        flags_q <= MWA_FLAGS_RST; // RULE_05
        copy_q <= '0;
      end else begin
        accLo_q <= accLo_d;
        accHi_q <= accHi_d;
        ext_q <= ext_d;
        sticky_q <= sticky_d;
        mask_q <= mask_d;
        flags_q <= flags_d;
        copy_q <= copy_d;
      end
    end

    always_comb begin
      case (rdDec.idx)
        MWA_IDX_LOW_L: blkRd[g] = accLo_q[31:0];
        MWA_IDX_LOW_H: blkRd[g] = accLo_q[63:32];
        MWA_IDX_HIGH_L: blkRd[g] = accHi_q[31:0];
        MWA_IDX_HIGH_H: blkRd[g] = accHi_q[63:32];
        MWA_IDX_EXT: blkRd[g] = ext_q;
        MWA_IDX_STATUS: blkRd[g] = {27'h0, flags_q, sticky_q};
        MWA_IDX_MASK: blkRd[g] = {31'h0, mask_q};
        default: blkRd[g] = 32'h0;
      endcase
    end

    assign blkIrq[g] = sticky_q && mask_q;
    assign copyOut[g] = copy_q;
  end

  // ---------------------------------------------------------------------------
  // Assertions on the first compute block
  // ---------------------------------------------------------------------------
  logic iss0;
  logic signed [63:0] chkProd;
  assign iss0 = opValid && op.blockSel[0];
  assign chkProd = $signed(op.opA) * $signed(op.opB);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  ext_half_a: assert property (iss0 && !op.accHigh |=> // RULE_04
      g_blk[0].ext_q[31:16] == $past(g_blk[0].ext_q[31:16]))
    else $error("Upper extension half changed on low-pair accumulate.");

  sticky_hold_a: assert property (g_blk[0].sticky_q && !g_blk[0].stickyClr // RULE_17
      |=> g_blk[0].sticky_q)
    else $error("Sticky overflow dropped without a software clear.");

  no_flag_a: assert property (iss0 && op.noFlag && !g_blk[0].sticky_q // RULE_10
      |=> !g_blk[0].sticky_q)
    else $error("Sticky overflow set despite the no-flag option.");

  flags_keep_a: assert property (iss0 |=> $stable(g_blk[0].flags_q)) // RULE_05
    else $error("Multiplier flags changed by an accumulate.");

  clear_load_a: assert property (iss0 && op.clear && op.integerOp && !op.subtract // RULE_09
      && !op.accHigh |=> g_blk[0].accLo_q == $past(chkProd))
    else $error("Cleared accumulate does not hold the product.");

  copy_pair_a: assert property (iss0 && op.dual && op.pairDest && !op.accHigh // RULE_11
      && g_blk[0].ext_q[15:0] == 16'h0 && !g_blk[0].accLo_q[63]
      |=> copyOut[0].valid && copyOut[0].data == $past(g_blk[0].accLo_q))
    else $error("Pair copy-out does not carry the old accumulator.");

  copy_single_a: assert property (iss0 && op.dual && !op.pairDest && op.integerOp // RULE_14
      && !op.accHigh && g_blk[0].ext_q[15:0] == 16'h0 && !g_blk[0].accLo_q[63]
      |=> copyOut[0].data == {32'h0, $past(g_blk[0].accLo_q[31:0])})
    else $error("Single integer copy-out is not the low word.");

  sat_pos_a: assert property (iss0 && op.dual && op.pairDest && !op.accHigh // RULE_16
      && (op.subtract || !op.unsignedOp) && !op.noFlag && !g_blk[0].ext_q[15]
      && g_blk[0].ext_q[15:0] != {16{g_blk[0].accLo_q[63]}}
      |=> copyOut[0].data == MWA_SAT_POS && g_blk[0].sticky_q)
    else $error("Signed copy-out beyond 64 bits not saturated.");

  // ---------------------------------------------------------------------------
  // Assertions on the bus, the second block and the remaining options
  // ---------------------------------------------------------------------------
  // These check outputs and state against the inputs of one cycle, so they stay
  // valid whatever order the sequencer and software choose for their requests.
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Bus acknowledge lasted more than one cycle.");

  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o)
    else $error("Bus request not acknowledged in the next cycle.");

  copy_idle_a: assert property (!(iss0 && op.dual) // RULE_11
      |=> !copyOut[0].valid)
    else $error("Copy-out strobe without a dual instruction.");

  dual_keep_a: assert property (iss0 && op.dual |=> copyOut[0].valid) // RULE_11
    else $error("Dual instruction gave no copy-out strobe.");

  blk1_quiet_a: assert property (!(opValid && op.blockSel[1]) && !g_blk[1].wrHere // RULE_18
      |=> $stable(g_blk[1].accLo_q) && $stable(g_blk[1].ext_q))
    else $error("Second block changed without being selected.");

  blk0_quiet_a: assert property (opValid && !op.blockSel[0] && !g_blk[0].wrHere // RULE_18
      |=> $stable(g_blk[0].accLo_q) && $stable(g_blk[0].accHi_q))
    else $error("First block changed without being selected.");

  ext_low_a: assert property (iss0 && op.accHigh // RULE_04
      |=> g_blk[0].ext_q[15:0] == $past(g_blk[0].ext_q[15:0]))
    else $error("Lower extension half changed on high-pair accumulate.");

  sticky_set_a: assert property (iss0 && !op.noFlag && g_blk[0].ovf // RULE_06
      |=> g_blk[0].sticky_q)
    else $error("Accumulate overflow did not set the sticky flag.");

  uns_sat_a: assert property (iss0 && op.dual && op.pairDest && !op.accHigh // RULE_13
      && !op.subtract && op.unsignedOp && g_blk[0].ext_q[15:0] != 16'h0
      |=> copyOut[0].data == MWA_SAT_UNS)
    else $error("Unsigned copy-out leaked extension bits.");

  single_hi_a: assert property (iss0 && op.dual && !op.pairDest // RULE_14
      |=> copyOut[0].data[63:32] == 32'h0)
    else $error("Single copy-out carries upper bits.");

  round_load_a: assert property (iss0 && op.clearRound && !op.clear && !op.integerOp // RULE_09
      && !op.accHigh && op.opA == 32'h0
      |=> g_blk[0].accLo_q == MWA_ROUND[63:0])
    else $error("Clear-and-round did not preload the rounding value.");

  copy_ovf_a: assert property (iss0 && op.dual && !op.pairDest && op.integerOp // RULE_15
      && !op.unsignedOp && !op.noFlag && !op.accHigh
      && g_blk[0].accLo_q[63:31] != 33'h0
      && g_blk[0].accLo_q[63:31] != 33'h1FFFFFFFF
      |=> g_blk[0].sticky_q)
    else $error("Single signed copy beyond 32 bits left sticky clear.");

  mask_gate_a: assert property (!g_blk[0].mask_q && !g_blk[1].mask_q |-> !irq)
    else $error("Interrupt raised with both masks clear.");

  cov_dual_c: cover property (iss0 && op.dual && op.clear ##1 copyOut[0].valid);
  cov_sat_c: cover property (iss0 && op.dual && g_blk[0].copyOvf);
  cov_irq_c: cover property (irq ##1 !irq);
  cov_both_c: cover property (opValid && op.blockSel == 2'b11);
  cov_uns_sat_c: cover property (iss0 && op.dual && op.unsignedOp
      && g_blk[0].ext_q[15:0] != 16'h0);

endmodule

`default_nettype wire

// ### verif/mwa_rf_model.sv
`default_nettype none

module mwa_rf_model
  import mwa_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire mwa_copy_t [1:0] copyOut,
  output logic [1:0][63:0] rfData,
  output logic [1:0][7:0] rfWrites
);
  // ---------------------------------------------------------------------------
  // Register file sink
  // ---------------------------------------------------------------------------
  // The whole word is kept, so stray upper bits on a single copy are not hidden.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rfData <= '0;
      rfWrites <= '0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (copyOut[b].valid) begin
          rfData[b] <= copyOut[b].data;
          rfWrites[b] <= rfWrites[b] + 8'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ### verif/mwa_mac_tb.sv
`default_nettype none

module mwa_mac_tb import mwa_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0] HI = 9'h100;
  localparam logic [8:0] SUB = 9'h080;
  localparam logic [8:0] UNS = 9'h040;
  localparam logic [8:0] INT = 9'h020;
  localparam logic [8:0] CLR = 9'h010;
  localparam logic [8:0] CR = 9'h008;
  localparam logic [8:0] NF = 9'h004;
  localparam logic [8:0] DUAL = 9'h002;
  localparam logic [8:0] PAIR = 9'h001;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic opValid = 1'b0;
  mwa_op_t op = '0;
  mwa_copy_t [1:0] copyOut;
  logic irq;
  logic [1:0][63:0] rfData;
  logic [1:0][7:0] rfWrites;
  int err_total = 0;
  int checks = 0;

  mwa_mac mwa_mac_i (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .opValid(opValid),
    .op(op), .copyOut(copyOut), .irq(irq));
  mwa_rf_model mwa_rf_model_i (.core_clk(core_clk), .resetn(resetn), .copyOut(copyOut),
    .rfData(rfData), .rfWrites(rfWrites));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic close_out;
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // The request stays put until ack is seen; the bound stops a dead slave hanging us.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      close_out();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic cr(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk({32'h0, q}, {32'h0, e});
  endtask

  task automatic cr64(input logic [7:0] a, input logic [63:0] e);
    logic [31:0] lo;
    logic [31:0] hi;
    bus(1'b0, a, 32'h0, lo);
    bus(1'b0, a + 8'h04, 32'h0, hi);
    chk({hi, lo}, e);
  endtask

  task automatic mac(input logic [1:0] bs, input logic [8:0] f, input logic [31:0] a,
                     input logic [31:0] b);
    opValid <= 1'b1;
    op <= {bs, f, a, b};
    @(posedge core_clk);
  endtask

  task automatic idle;
    opValid <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic ovf(input logic [31:0] ext, input logic [8:0] f);
    wr(8'h00, 32'hFFFFFFFF);
    wr(8'h04, 32'hFFFFFFFF);
    wr(8'h10, ext);
    mac(2'h1, f, 32'h1, 32'h1);
    idle();
    cr(8'h14, 32'h1F);
    wr(8'h14, 32'h1F);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      cr(8'(i * 4), 32'h0);
    end
  endtask

  task automatic t_accumulate;
    mac(2'h1, HI | SUB | INT, 32'h2, 32'h5);
    idle();
    cr64(8'h08, 64'hFFFFFFFFFFFFFFF6);
    cr(8'h10, 32'hFFFF0000);
    mac(2'h1, HI | SUB | INT, 32'hFFFFFFF6, 32'h6);
    idle();
    cr64(8'h08, 64'h32);
    wr(8'h14, 32'h1E);
    mac(2'h1, UNS | INT, 32'hF0060054, 32'hF036AC42);
    mac(2'h1, UNS | INT, 32'hF0060054, 32'hF036AC42);
    idle();
    cr64(8'h00, 64'hC271C629_76F90B50);
    cr(8'h10, 32'h1);
    cr(8'h14, 32'h1E);
  endtask

  task automatic t_dual;
    mac(2'h1, UNS | INT | CLR | DUAL | PAIR, 32'h2, 32'h5);
    idle();
    chk(rfData[0], 64'hFFFFFFFFFFFFFFFF);
    cr(8'h10, 32'h0);
    mac(2'h1, UNS | INT | CLR | DUAL, 32'hA, 32'h6);
    idle();
    chk(rfData[0], 64'hA);
    cr64(8'h00, 64'h3C);
    chk({56'h0, rfWrites[0]}, 64'h2);
  endtask

  task automatic t_sticky;
    wr(8'h04, 32'h1);
    mac(2'h1, INT | DUAL | NF, 32'h0, 32'h0);
    idle();
    cr(8'h14, 32'h1E);
    mac(2'h1, INT | DUAL, 32'h0, 32'h0);
    idle();
    chk(rfData[0], 64'h3C);
    cr(8'h14, 32'h1F);
    chk({63'h0, irq}, 64'h0);
    wr(8'h18, 32'h1);
    chk({63'h0, irq}, 64'h1);
    mac(2'h1, INT, 32'h1, 32'h1);
    idle();
    cr(8'h14, 32'h1F);
    wr(8'h14, 32'h1F);
    cr(8'h14, 32'h1E);
    chk({63'h0, irq}, 64'h0);
  endtask

  task automatic t_saturate;
    wr(8'h08, 32'h12345678);
    wr(8'h0C, 32'hFFFFFFFF);
    wr(8'h10, 32'h7FFF0000);
    mac(2'h1, HI | DUAL | PAIR, 32'h4236745D, 32'h53ACBE34);
    idle();
    chk(rfData[0], 64'h7FFFFFFFFFFFFFFF);
    wr(8'h10, 32'h00007FFF);
    mac(2'h1, DUAL | PAIR, 32'h0, 32'h0);
    idle();
    chk(rfData[0], 64'h7FFFFFFFFFFFFFFF);
    cr(8'h14, 32'h1F);
    wr(8'h14, 32'h1F);
    ovf(32'h0000FFFF, UNS | INT);
    ovf(32'h00007FFF, INT);
    ovf(32'h00007FFF, 9'h000);
  endtask

  task automatic t_options;
    mac(2'h1, SUB | UNS | INT | CLR, 32'h2, 32'hFFFFFFFF);
    idle();
    cr64(8'h00, 64'h2);
    cr(8'h10, 32'h0);
    mac(2'h1, CR, 32'h0, 32'h0);
    idle();
    cr64(8'h00, 64'h80000000);
    mac(2'h2, INT | CLR, 32'h3, 32'h4);
    idle();
    cr64(8'h20, 64'hC);
    cr64(8'h00, 64'h80000000);
    mac(2'h3, INT, 32'h1, 32'h1);
    idle();
    cr64(8'h20, 64'hD);
    cr64(8'h00, 64'h80000001);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_accumulate();
    t_dual();
    t_sticky();
    t_saturate();
    t_options();
    close_out();
  end
endmodule

`default_nettype wire
